// [common/sfd_defines.vh]
/*
 Constants for the serial flash command decoder: opcodes, phase sizes,
 dummy-cycle defaults, opcode classes, lane counts and address-map field positions.
 Assumes inclusion by bare name from the design files.
*/
`ifndef SFD_DEFINES_VH
`define SFD_DEFINES_VH

// ----------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------
`define SFD_OP_READ         8'h03
`define SFD_OP_FAST_READ    8'h0B
`define SFD_OP_DUAL_IO      8'hBB
`define SFD_OP_DUAL_OUT     8'h3B
`define SFD_OP_QUAD_IO      8'hEB
`define SFD_OP_QUAD_OUT     8'h6B
`define SFD_OP_PAGE_PROG    8'h02
`define SFD_OP_QUAD_PROG    8'h38
`define SFD_OP_WIPE_4K      8'h20
`define SFD_OP_ERASE_32K    8'h52
`define SFD_OP_ERASE_64K    8'hD8
`define SFD_OP_CHIP_ERASE_A 8'h60
`define SFD_OP_CHIP_ERASE_B 8'hC7
`define SFD_OP_WR_UNLOCK    8'h06
`define SFD_OP_WR_LOCK      8'h04
`define SFD_OP_SUSPEND      8'hB0
`define SFD_OP_RESUME       8'h30
`define SFD_OP_SLEEP_ENTRY  8'hB9
`define SFD_OP_SLEEP_EXIT   8'hAB
`define SFD_OP_IDLE         8'h00
`define SFD_OP_RESET_ARM    8'h66
`define SFD_OP_RESET_EXEC   8'h99
`define SFD_OP_SEC_WRITE    8'h2F
`define SFD_OP_STATUS_READ  8'h05

// ----------------------------------------------------------------------
// Opcode classes
// ----------------------------------------------------------------------
`define SFD_CLS_BAD   3'h0
`define SFD_CLS_READ  3'h1
`define SFD_CLS_PROG  3'h2
`define SFD_CLS_ERASE 3'h3
`define SFD_CLS_BARE  3'h4
`define SFD_CLS_STAT  3'h5
`define SFD_CLS_WBARE 3'h6

// ----------------------------------------------------------------------
// Phase sizes and dummy cycles
// ----------------------------------------------------------------------
`define SFD_ADDR_BYTES   2'h3
`define SFD_DUMMY_FAST   4'h8
`define SFD_DUMMY_DUAL   4'h4
`define SFD_DUMMY_QUAD   4'h6
`define SFD_DUMMY_STEP   4'h2
`define SFD_LANES_1      3'h1
`define SFD_LANES_2      3'h2
`define SFD_LANES_4      3'h4

// ----------------------------------------------------------------------
// Address map
// ----------------------------------------------------------------------
`define SFD_SECTOR_LSB   12
`define SFD_BLK32_LSB    15
`define SFD_BLK64_LSB    16
`define SFD_TOP_SECTOR   12'hFFF

`endif

// [design/sfd_addr_map.v]
/*
 Address map: splits a 24-bit flash address into 4 KB sector,
 32 KB block and 64 KB block numbers, registered.
 Assumes the address is stable in the sys_clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sfd_defines.vh"

module sfd_addr_map #(
   parameter ADDR_W = 24
) (
   input  wire              sys_clk,
   input  wire              resetn,
   input  wire [ADDR_W-1:0] addr,
   output reg  [11:0]       sector,
   output reg  [8:0]        blk32,
   output reg  [7:0]        blk64,
   output reg               top_sector
);

   // ----------------------------------------------------------------
   // Registered decode
   // ----------------------------------------------------------------
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sector     <= 12'h000;
         blk32      <= 9'h000;
         blk64      <= 8'h00;
         top_sector <= 1'b0;
      end else begin
         sector     <= addr[ADDR_W-1:`SFD_SECTOR_LSB]; // RULE9
         blk32      <= addr[ADDR_W-1:`SFD_BLK32_LSB]; // RULE9
         blk64      <= addr[ADDR_W-1:`SFD_BLK64_LSB]; // RULE9
         top_sector <= (addr[ADDR_W-1:`SFD_SECTOR_LSB] == `SFD_TOP_SECTOR); // RULE9
      end
   end

endmodule // sfd_addr_map

`default_nettype wire

// [design/sfd_cmd_decoder.v]
/*
 Serial flash command front end: frames opcode, address, dummy and data
 phases on a select-gated serial bus and decodes array and device commands.
 Assumes pins are asynchronous to sys_clk and the serial clock is much
 slower than sys_clk; array data follows rd_addr within a few sys_clk.
*/
// What this block does
// RULE1: Unknown or refused command: standby until next select fall, outputs off.
// RULE2: Valid command keeps the block active until select rises.
// RULE3: Sample input on serial clock rise, launch output on fall.
// RULE4: Works with serial clock idling low or high.
// RULE5: Reads end cleanly whenever select rises during data out.
// RULE6: Write-type commands execute only if select rises on a byte boundary.
// RULE7: While busy, array accesses are ignored without disturbing the operation.
// RULE8: Host checks status before issuing commands.
// RULE9: Address splits into 4 KB sectors, 32 KB and 64 KB blocks.
// RULE10: Opcode 03h: three address bytes, no dummy, streamed data.
// RULE11: Opcode 0Bh: three address bytes, eight dummy cycles, streamed data.
// RULE12: Opcode BBh: address and data on two lines, four dummy cycles.
// RULE13: Opcodes 3Bh and 6Bh: single address, eight dummy, dual/quad data.
// RULE14: Opcode EBh: address and data on four lines, six dummy cycles.
// RULE15: Dummy counts follow the two configuration dummy bits.
// RULE16: Opcodes 02h and 38h: three address bytes then 1 to 256 bytes.
// RULE17: Erases 20h, 52h, D8h take addresses; 60h and C7h do not.
// RULE18: 06h sets the write latch, 04h clears it.
// RULE19: B0h suspends and 30h resumes program or erase.
// RULE20: B9h enters deep sleep, ABh leaves it.
// RULE21: 00h is accepted with no effect.
// RULE22: 66h arms software reset, 99h carries it out.
// RULE23: Reset execute is ignored unless reset arm came first with no other bare command and no data-out phase between; 60h, C7h, 2Fh do not disarm.
// RULE24: Program, erase and security write need the write latch set.
// RULE25: In deep sleep only release, signature and reset commands are taken.
// RULE26: Busy flag shows a program or erase still running.
// RULE27: Select rise clears the cycle and byte counters and the decode phase.
// RULE28: Address bytes assemble most significant first before later phases.
`timescale 1ns/1ps
`default_nettype none
`include "sfd_defines.vh"

module sfd_cmd_decoder #(
   parameter ADDR_W = 24,
   parameter PAGE_BYTES = 256
) (
   input  wire              sys_clk,
   input  wire              resetn,
   input  wire              select_n,
   input  wire              serial_clock,
   input  wire [3:0]        sio_in,
   output reg  [3:0]        sio_out,
   output reg  [3:0]        sio_oe,
   input  wire [1:0]        dummy_cfg_bits,
   input  wire              busy_flag,
   input  wire [7:0]        rd_data,
   output reg  [ADDR_W-1:0] rd_addr,
   output reg  [7:0]        pg_data,
   output reg               pg_valid,
   output reg               exec_pulse,
   output reg  [7:0]        exec_op,
   output reg  [ADDR_W-1:0] exec_addr,
   output wire              write_latch,
   output wire              deep_sleep,
   output wire              cmd_active,
   output wire [11:0]       sector,
   output wire [8:0]        blk32,
   output wire [7:0]        blk64,
   output wire              top_sector
);

   // ----------------------------------------------------------------
   // States
   // ----------------------------------------------------------------
   localparam [6:0] ST_OPC  = 7'h01;
   localparam [6:0] ST_ADDR = 7'h02;
   localparam [6:0] ST_DUM  = 7'h04;
   localparam [6:0] ST_DOUT = 7'h08;
   localparam [6:0] ST_DIN  = 7'h10;
   localparam [6:0] ST_WAIT = 7'h20;
   localparam [6:0] ST_STBY = 7'h40;

   // ----------------------------------------------------------------
   // Decode functions
   // ----------------------------------------------------------------
   function [2:0] op_class;
      input [7:0] op;
      begin
         case (op)
            `SFD_OP_READ, `SFD_OP_FAST_READ, `SFD_OP_DUAL_IO, `SFD_OP_DUAL_OUT,
            `SFD_OP_QUAD_IO, `SFD_OP_QUAD_OUT: op_class = `SFD_CLS_READ;
            `SFD_OP_PAGE_PROG, `SFD_OP_QUAD_PROG: op_class = `SFD_CLS_PROG;
            `SFD_OP_WIPE_4K, `SFD_OP_ERASE_32K,
            `SFD_OP_ERASE_64K: op_class = `SFD_CLS_ERASE;
            `SFD_OP_CHIP_ERASE_A, `SFD_OP_CHIP_ERASE_B,
            `SFD_OP_SEC_WRITE: op_class = `SFD_CLS_WBARE;
            `SFD_OP_WR_UNLOCK, `SFD_OP_WR_LOCK, `SFD_OP_SUSPEND, `SFD_OP_RESUME,
            `SFD_OP_SLEEP_ENTRY, `SFD_OP_SLEEP_EXIT, `SFD_OP_IDLE,
            `SFD_OP_RESET_ARM, `SFD_OP_RESET_EXEC: op_class = `SFD_CLS_BARE;
            `SFD_OP_STATUS_READ: op_class = `SFD_CLS_STAT;
            default: op_class = `SFD_CLS_BAD;
         endcase
      end
   endfunction

   function [2:0] addr_lanes;
      input [7:0] op;
      begin
         case (op)
            `SFD_OP_DUAL_IO: addr_lanes = `SFD_LANES_2; // RULE12
            `SFD_OP_QUAD_IO: addr_lanes = `SFD_LANES_4; // RULE14
            default:         addr_lanes = `SFD_LANES_1;
         endcase
      end
   endfunction

   function [2:0] data_lanes;
      input [7:0] op;
      begin
         case (op)
            `SFD_OP_DUAL_IO, `SFD_OP_DUAL_OUT: data_lanes = `SFD_LANES_2; // RULE13
            `SFD_OP_QUAD_IO, `SFD_OP_QUAD_OUT,
            `SFD_OP_QUAD_PROG:                 data_lanes = `SFD_LANES_4; // RULE13
            default:                           data_lanes = `SFD_LANES_1;
         endcase
      end
   endfunction

   function [3:0] dummy_len;
      input [7:0] op;
      input [1:0] cfg;
      reg   [3:0] base;
      begin
         case (op)
            `SFD_OP_FAST_READ, `SFD_OP_DUAL_OUT,
            `SFD_OP_QUAD_OUT: base = `SFD_DUMMY_FAST; // RULE11 RULE13
            `SFD_OP_DUAL_IO:  base = `SFD_DUMMY_DUAL; // RULE12
            `SFD_OP_QUAD_IO:  base = `SFD_DUMMY_QUAD; // RULE14
            default:          base = 4'h0; // RULE10
         endcase
         if (base == 4'h0)
            dummy_len = 4'h0;
         else
            dummy_len = base - `SFD_DUMMY_STEP * {2'h0, cfg}; // RULE15
      end
   endfunction

   function [3:0] lane_bits;
      input [7:0] b;
      input [2:0] lanes;
      begin
         case (lanes)
            `SFD_LANES_4: lane_bits = b[7:4];
            `SFD_LANES_2: lane_bits = {2'h0, b[7:6]};
            default:      lane_bits = {2'h0, b[7], 1'b0};
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisers and edges
   // ----------------------------------------------------------------
   reg  [5:0] sync1_q;
   reg  [5:0] sync2_q;
   reg        sclk_prev_q;
   reg        sel_prev_q;
   wire       sel_n_s  = sync2_q[5];
   wire       sclk_s   = sync2_q[4];
   wire [3:0] sio_s    = sync2_q[3:0];
   wire       sclk_ris = sclk_s & ~sclk_prev_q; // RULE3 RULE4
   wire       sclk_fal = ~sclk_s & sclk_prev_q; // RULE3 RULE4
   wire       sel_rise = sel_n_s & ~sel_prev_q;
   wire       sel_low  = ~sel_n_s;

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sync1_q     <= 6'h3F;
         sync2_q     <= 6'h3F;
         sclk_prev_q <= 1'b1;
         sel_prev_q  <= 1'b1;
      end else begin
         sync1_q     <= {select_n, serial_clock, sio_in};
         sync2_q     <= sync1_q;
         sclk_prev_q <= sclk_s;
         sel_prev_q  <= sel_n_s;
      end
   end

   // ----------------------------------------------------------------
   // Framing state
   // ----------------------------------------------------------------
   reg  [6:0]        state_q;
   reg  [7:0]        op_q;
   reg  [7:0]        shift_q;
   reg  [2:0]        cyc_q;
   reg  [1:0]        abyte_q;
   reg  [3:0]        dum_q;
   reg  [8:0]        dbyte_q;
   reg  [ADDR_W-1:0] addr_q;
   reg  [7:0]        out_sh_q;
   reg  [2:0]        out_cyc_q;
   reg               first_q;
   reg               latch_q;
   reg               sleep_q;
   reg               armed_q;

   wire [2:0] cls      = op_class(op_q);
   wire [2:0] in_lanes = (state_q == ST_ADDR) ? addr_lanes(op_q) :
                         (state_q == ST_DIN)  ? data_lanes(op_q) : `SFD_LANES_1;
   wire [2:0] o_lanes  = data_lanes(op_q);
   reg  [7:0] shift_d;
   wire [2:0] in_last  = 3'h7 >> (in_lanes >> 1);
   wire [2:0] out_last = 3'h7 >> (o_lanes >> 1);
   wire       byte_in  = (cyc_q == in_last);
   wire [7:0] out_src  = (cls == `SFD_CLS_STAT) ?
                         {6'h00, latch_q, busy_flag} : rd_data; // RULE26

   always @* begin
      case (in_lanes)
         `SFD_LANES_4: shift_d = {shift_q[3:0], sio_s};
         `SFD_LANES_2: shift_d = {shift_q[5:0], sio_s[1:0]};
         default:      shift_d = {shift_q[6:0], sio_s[0]};
      endcase
   end

   // Opcode admission check
   reg        admit;
   reg  [2:0] ncls;
   always @* begin
      ncls  = op_class(shift_d);
      admit = (ncls != `SFD_CLS_BAD);
      if (sleep_q && shift_d != `SFD_OP_SLEEP_EXIT && shift_d != `SFD_OP_RESET_ARM
          && shift_d != `SFD_OP_RESET_EXEC)
         admit = 1'b0; // RULE25
      if (busy_flag && (ncls == `SFD_CLS_READ || ncls == `SFD_CLS_PROG ||
          ncls == `SFD_CLS_ERASE || ncls == `SFD_CLS_WBARE))
         admit = 1'b0; // RULE7
      if (!latch_q && (ncls == `SFD_CLS_PROG || ncls == `SFD_CLS_ERASE ||
          ncls == `SFD_CLS_WBARE))
         admit = 1'b0; // RULE24
   end

   // Completion check at select rise
   wire byte_edge = (cyc_q == 3'h0);
   wire done_ok   = byte_edge &&
                    ((state_q == ST_WAIT) ||
                     (state_q == ST_DIN && dbyte_q != 9'h000)); // RULE6 RULE16

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_q    <= ST_OPC;
         op_q       <= 8'h00;
         shift_q    <= 8'h00;
         cyc_q      <= 3'h0;
         abyte_q    <= 2'h0;
         dum_q      <= 4'h0;
         dbyte_q    <= 9'h000;
         addr_q     <= {ADDR_W{1'b0}};
         rd_addr    <= {ADDR_W{1'b0}};
         out_sh_q   <= 8'h00;
         out_cyc_q  <= 3'h0;
         first_q    <= 1'b0;
         sio_out    <= 4'h0;
         sio_oe     <= 4'h0;
         pg_data    <= 8'h00;
         pg_valid   <= 1'b0;
         exec_pulse <= 1'b0;
         exec_op    <= 8'h00;
         exec_addr  <= {ADDR_W{1'b0}};
         latch_q    <= 1'b0;
         sleep_q    <= 1'b0;
         armed_q    <= 1'b0;
      end else begin
         pg_valid   <= 1'b0;
         exec_pulse <= 1'b0;
         if (sel_rise) begin
            // Fresh framing on every select rise
            state_q   <= ST_OPC; // RULE27 RULE2
            cyc_q     <= 3'h0; // RULE27
            abyte_q   <= 2'h0; // RULE27
            dbyte_q   <= 9'h000; // RULE27
            out_cyc_q <= 3'h0;
            sio_oe    <= 4'h0; // RULE5
            if (state_q == ST_DOUT || (state_q == ST_WAIT && cls == `SFD_CLS_BARE
                && op_q != `SFD_OP_RESET_ARM))
               armed_q <= 1'b0; // RULE23
            if (done_ok) begin
               exec_pulse <= 1'b1; // RULE6
               exec_op    <= op_q;
               exec_addr  <= addr_q;
               case (op_q)
                  `SFD_OP_WR_UNLOCK:   latch_q <= 1'b1; // RULE18
                  `SFD_OP_WR_LOCK:     latch_q <= 1'b0; // RULE18
                  `SFD_OP_SUSPEND:     latch_q <= 1'b0; // RULE19
                  `SFD_OP_SLEEP_ENTRY: sleep_q <= 1'b1; // RULE20
                  `SFD_OP_SLEEP_EXIT:  sleep_q <= 1'b0; // RULE20
                  `SFD_OP_RESET_ARM:   armed_q <= 1'b1; // RULE22
                  `SFD_OP_RESET_EXEC: begin
                     if (armed_q) begin
                        latch_q <= 1'b0; // RULE22
                        sleep_q <= 1'b0;
                     end
                     armed_q <= 1'b0; // RULE23
                  end
                  default: begin
                     if (cls != `SFD_CLS_BARE)
                        latch_q <= 1'b0; // RULE17 RULE24
                  end
               endcase
            end
         end else if (sel_low && sclk_ris) begin
            // Input sampling on the rising serial edge
            shift_q <= shift_d; // RULE3
            cyc_q   <= byte_in ? 3'h0 : cyc_q + 3'h1;
            case (state_q)
               ST_OPC: begin
                  if (byte_in) begin
                     op_q <= shift_d;
                     if (!admit)
                        state_q <= ST_STBY; // RULE1
                     else if (ncls == `SFD_CLS_READ || ncls == `SFD_CLS_PROG ||
                              ncls == `SFD_CLS_ERASE)
                        state_q <= ST_ADDR; // RULE2
                     else if (ncls == `SFD_CLS_STAT) begin
                        state_q <= ST_DOUT;
                        first_q <= 1'b1;
                     end else
                        state_q <= ST_WAIT; // RULE21
                  end
               end
               ST_ADDR: begin
                  if (byte_in) begin
                     addr_q  <= {addr_q[ADDR_W-9:0], shift_d}; // RULE28
                     abyte_q <= abyte_q + 2'h1;
                     if (abyte_q == `SFD_ADDR_BYTES - 2'h1) begin
                        rd_addr <= {addr_q[ADDR_W-9:0], shift_d}; // RULE28
                        dum_q   <= dummy_len(op_q, dummy_cfg_bits); // RULE15
                        first_q <= 1'b1;
                        if (cls == `SFD_CLS_PROG)
                           state_q <= ST_DIN; // RULE16
                        else if (cls == `SFD_CLS_ERASE)
                           state_q <= ST_WAIT; // RULE17
                        else if (dummy_len(op_q, dummy_cfg_bits) == 4'h0)
                           state_q <= ST_DOUT; // RULE10
                        else
                           state_q <= ST_DUM; // RULE11
                     end
                  end
               end
               ST_DUM: begin
                  cyc_q <= 3'h0;
                  dum_q <= dum_q - 4'h1;
                  if (dum_q == 4'h1)
                     state_q <= ST_DOUT; // RULE11 RULE12 RULE14
               end
               ST_DIN: begin
                  if (byte_in) begin
                     pg_data  <= shift_d; // RULE16
                     pg_valid <= 1'b1;
                     if (dbyte_q != PAGE_BYTES[8:0])
                        dbyte_q <= dbyte_q + 9'h001;
                  end
               end
               ST_WAIT: state_q <= ST_STBY; // RULE6
               ST_DOUT: cyc_q <= 3'h0;
               ST_STBY: cyc_q <= 3'h0; // RULE1
               default: state_q <= ST_STBY;
            endcase
         end else if (sel_low && sclk_fal && state_q == ST_DOUT) begin
            // Output launch on the falling serial edge
            sio_oe <= (o_lanes == `SFD_LANES_4) ? 4'hF :
                      (o_lanes == `SFD_LANES_2) ? 4'h3 : 4'h2; // RULE3
            if (first_q || out_cyc_q == out_last) begin
               first_q   <= 1'b0;
               out_cyc_q <= 3'h0;
               sio_out   <= lane_bits(out_src, o_lanes);
               out_sh_q  <= out_src << o_lanes;
               rd_addr   <= rd_addr + {{(ADDR_W-1){1'b0}}, 1'b1}; // RULE10
            end else begin
               out_cyc_q <= out_cyc_q + 3'h1;
               sio_out   <= lane_bits(out_sh_q, o_lanes);
               out_sh_q  <= out_sh_q << o_lanes;
            end
         end
      end
   end

   assign write_latch = latch_q;
   assign deep_sleep  = sleep_q;
   assign cmd_active  = sel_low && (state_q != ST_OPC) && (state_q != ST_STBY); // RULE2

   // ----------------------------------------------------------------
   // Address map
   // ----------------------------------------------------------------
   sfd_addr_map #(
      .ADDR_W (ADDR_W)
   ) u_map (
      .sys_clk    (sys_clk),
      .resetn     (resetn),
      .addr       (addr_q),
      .sector     (sector),
      .blk32      (blk32),
      .blk64      (blk64),
      .top_sector (top_sector)
   );

endmodule // sfd_cmd_decoder

`default_nettype wire

// [bench/sfd_cmd_chk.sv]
/*
 Checker for sfd_cmd_decoder: timing relations at its ports.
 Assumes binding into every sfd_cmd_decoder instance.
*/
`timescale 1ns/1ps
`default_nettype none
module sfd_cmd_chk (
   input wire logic        sys_clk,
   input wire logic        resetn,
   input wire logic        select_n,
   input wire logic [3:0]  sio_oe,
   input wire logic        exec_pulse,
   input wire logic [7:0]  exec_op,
   input wire logic        write_latch,
   input wire logic        deep_sleep,
   input wire logic        pg_valid,
   input wire logic [11:0] sector,
   input wire logic [8:0]  blk32,
   input wire logic [7:0]  blk64,
   input wire logic        top_sector
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   sequence sel_quiet;
      select_n [*4];
   endsequence
   sequence one_shot(sig);
      sig ##1 !sig;
   endsequence
   a_oe_off_idle: assert property (sel_quiet |-> sio_oe == 4'h0)
      else $error("output enable on while deselected");
   a_exec_single: assert property (exec_pulse |-> one_shot(exec_pulse))
      else $error("exec pulse longer than one cycle");
   a_exec_sel_hi: assert property (exec_pulse |-> $past(select_n, 2))
      else $error("exec pulse before select rise");
   a_latch_set_op: assert property ($rose(write_latch) |-> exec_pulse && exec_op == 8'h06)
      else $error("write latch set without unlock");
   a_sleep_set_op: assert property ($rose(deep_sleep) |-> exec_pulse && exec_op == 8'hB9)
      else $error("sleep entered without sleep opcode");
   a_sleep_filter: assert property (exec_pulse && $past(deep_sleep)
      |-> exec_op inside {8'hAB, 8'h66, 8'h99})
      else $error("command executed while asleep");
   a_map_nested: assert property (blk32 == sector[11:3] && blk64 == sector[11:4]
      && top_sector == &sector)
      else $error("address map fields disagree");
   a_prog_single: assert property (pg_valid |=> !pg_valid)
      else $error("program strobe longer than one cycle");
   a_oe_lane_set: assert property (sio_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
      else $error("illegal output lane set");
endmodule // sfd_cmd_chk
bind sfd_cmd_decoder sfd_cmd_chk i_chk (.*);
`default_nettype wire

// [bench/sfd_host_model.sv]
/*
 Host model: mode 0/3 serial master, one half period is 4 sys_clk.
 Assumes the bench clock; data sampled from lane 1.
*/
`timescale 1ns/1ps
`default_nettype none
module sfd_host_model (
   input  wire logic       sys_clk,
   input  wire logic [3:0] sio_out,
   output var  logic       select_n,
   output var  logic       serial_clock,
   output var  logic [3:0] sio_in
);
   logic idle_hi = 1'b0;
   initial begin
      select_n = 1'b1;
      serial_clock = 1'b0;
      sio_in = 4'h5;
   end
   always @(posedge sys_clk) begin
      if (select_n) begin
         sio_in <= ~sio_in;
      end
   end
   task automatic bit_cycle(input logic b, output logic o);
      serial_clock <= 1'b0;
      sio_in <= {~sio_in[3:1], b};
      repeat (4) @(posedge sys_clk);
      serial_clock <= 1'b1;
      o = sio_out[1];
      repeat (4) @(posedge sys_clk);
   endtask
   task automatic send_byte(input logic [7:0] v);
      logic o;
      for (int i = 7; i >= 0; i--) bit_cycle(v[i], o);
   endtask
   task automatic read_byte(output logic [7:0] v);
      for (int i = 7; i >= 0; i--) bit_cycle(1'b0, v[i]);
   endtask
   task automatic open_frame();
      @(posedge sys_clk);
      select_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask
   task automatic close_frame();
      serial_clock <= idle_hi;
      repeat (4) @(posedge sys_clk);
      select_n <= 1'b1;
      repeat (8) @(posedge sys_clk);
   endtask
endmodule // sfd_host_model
`default_nettype wire

// [bench/sfd_cmd_decoder_bench.sv]
/*
 Bench for sfd_cmd_decoder: table of bare commands, then hand cases.
 Assumes the host model drives the serial pins.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sfd_defines.vh"
module sfd_cmd_decoder_bench;
   logic        sys_clk = 1'b0;
   logic        resetn = 1'b0;
   logic        busy_flag = 1'b0;
   logic [1:0]  dummy_cfg_bits = 2'b00;
   logic [7:0]  rd_data = 8'hA5;
   logic        select_n, serial_clock, pg_valid, exec_pulse, ob;
   logic        write_latch, deep_sleep, top_sector;
   logic [3:0]  sio_in, sio_out, sio_oe;
   logic [7:0]  pg_data, exec_op, blk64, rb, pg_seen;
   logic [23:0] exec_addr;
   logic [11:0] sector;
   logic [8:0]  blk32;
   int          error_cnt = 0, cmp_count = 0, exec_cnt = 0, cyc = 0;
   localparam logic [9:0] ROWS [7] = '{{`SFD_OP_WR_UNLOCK, 2'b11}, {`SFD_OP_IDLE, 2'b11},
      {`SFD_OP_WR_LOCK, 2'b10}, {8'hFF, 2'b00}, {`SFD_OP_WR_UNLOCK, 2'b11},
      {`SFD_OP_SUSPEND, 2'b10}, {`SFD_OP_RESUME, 2'b10}};
   localparam logic [7:0] ERASES [5] = '{8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7};
   always #12.5 sys_clk = ~sys_clk;
   sfd_host_model i_host (.sys_clk(sys_clk), .sio_out(sio_out), .select_n(select_n),
      .serial_clock(serial_clock), .sio_in(sio_in));
   sfd_cmd_decoder i_dut (.sys_clk(sys_clk), .resetn(resetn), .select_n(select_n),
      .serial_clock(serial_clock), .sio_in(sio_in), .sio_out(sio_out), .sio_oe(sio_oe),
      .dummy_cfg_bits(dummy_cfg_bits), .busy_flag(busy_flag), .rd_data(rd_data),
      .rd_addr(), .pg_data(pg_data), .pg_valid(pg_valid), .exec_pulse(exec_pulse),
      .exec_op(exec_op), .exec_addr(exec_addr), .write_latch(write_latch),
      .deep_sleep(deep_sleep), .cmd_active(), .sector(sector), .blk32(blk32),
      .blk64(blk64), .top_sector(top_sector));
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (exec_pulse === 1'b1) begin
         exec_cnt <= exec_cnt + 1;
      end
      if (pg_valid === 1'b1) begin
         pg_seen <= pg_data;
      end
      if (cyc == 20000) begin
         error_cnt++;
         give_verdict();
      end
   end
   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmd(input logic [7:0] op, input logic [23:0] a, input logic with_addr);
      exec_cnt = 0;
      i_host.open_frame();
      i_host.send_byte(op);
      if (with_addr) begin
         i_host.send_byte(a[23:16]);
         i_host.send_byte(a[15:8]);
         i_host.send_byte(a[7:0]);
      end
   endtask
   task automatic bare(input logic [7:0] op);
      cmd(op, 24'h0, 1'b0);
      i_host.close_frame();
   endtask
   initial begin
      repeat (5) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (4) @(posedge sys_clk);
      foreach (ROWS[i]) begin
         bare(ROWS[i][9:2]);
         chk("exec count", ROWS[i][1], exec_cnt);
         chk("write latch", ROWS[i][0], write_latch);
      end
      cmd(`SFD_OP_WR_UNLOCK, 24'h0, 1'b0);
      i_host.bit_cycle(1'b0, ob);
      i_host.close_frame();
      chk("partial exec", 0, exec_cnt);
      cmd(`SFD_OP_WIPE_4K, 24'h123456, 1'b1);
      i_host.close_frame();
      chk("locked erase", 0, exec_cnt);
      bare(`SFD_OP_WR_UNLOCK);
      cmd(`SFD_OP_PAGE_PROG, 24'h123456, 1'b1);
      i_host.send_byte(8'h5A);
      i_host.close_frame();
      chk("prog exec", 1, exec_cnt);
      chk("prog addr", 24'h123456, exec_addr);
      chk("prog data", 8'h5A, pg_seen);
      chk("sector", 12'h123, sector);
      chk("blk64", 8'h12, blk64);
      foreach (ERASES[i]) begin
         bare(`SFD_OP_WR_UNLOCK);
         cmd(ERASES[i], 24'hFFF000, i < 3);
         i_host.close_frame();
         chk("erase op", ERASES[i], exec_op);
      end
      chk("top sector", 1, top_sector);
      chk("blk32", 9'h1FF, blk32);
      cmd(`SFD_OP_READ, 24'hFFF000, 1'b1);
      i_host.read_byte(rb);
      chk("read data", 8'hA5, rb);
      chk("read enable", 4'h2, sio_oe);
      i_host.close_frame();
      chk("released enable", 0, sio_oe);
      busy_flag <= 1'b1;
      cmd(`SFD_OP_STATUS_READ, 24'h0, 1'b0);
      i_host.read_byte(rb);
      i_host.close_frame();
      chk("status", 8'h01, rb);
      cmd(`SFD_OP_READ, 24'h000100, 1'b1);
      i_host.read_byte(rb);
      chk("busy enable", 0, sio_oe);
      i_host.idle_hi = 1'b1;
      i_host.close_frame();
      busy_flag <= 1'b0;
      bare(`SFD_OP_SLEEP_ENTRY);
      chk("asleep", 1, deep_sleep);
      bare(`SFD_OP_WR_UNLOCK);
      chk("sleep refuse", 0, exec_cnt);
      bare(`SFD_OP_SLEEP_EXIT);
      chk("awake", 0, deep_sleep);
      bare(`SFD_OP_WR_UNLOCK);
      bare(`SFD_OP_RESET_ARM);
      bare(`SFD_OP_IDLE);
      bare(`SFD_OP_RESET_EXEC);
      chk("reset skipped", 1, write_latch);
      bare(`SFD_OP_RESET_ARM);
      bare(`SFD_OP_RESET_EXEC);
      chk("reset done", 0, write_latch);
      give_verdict();
   end
endmodule // sfd_cmd_decoder_bench
`default_nettype wire
